// *** core/tpm_timer.sv ***
// Three-phase motor PWM timer with APB register access.
`include "tpm_defs.svh"
module tpm_timer (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_CUTOFF_N,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  output logic [5:0] O_PHASE,
  output logic [5:0] O_PHASE_OE,
  output logic O_CARRIER_IRQ,
  output logic [2:0] O_PHASE_IRQ
);
  // Bus handshake state.
  tpm_pkg::tpm_bus_t bus_reg;
  // Control and data registers.
  logic [6:0] ctrl0_reg;
  logic [4:0] ctrl1_reg;
  logic [3:0] skip_n_reg;
  logic [15:0] carrier_set_reg;
  logic [2:0] special_reg;
  logic [7:0] dead_reg;
  logic [5:0] buf0_reg;
  logic [5:0] buf1_reg;
  logic [15:0] width_reg [3];
  logic [15:0] alt_reg [3];
  logic unlock_reg;
  // Timer state.
  logic [15:0] carrier_cnt_reg;
  logic half_reg;
  logic arm_reg;
  logic buf_new_reg;
  logic [5:0] sh0_reg;
  logic [5:0] sh1_reg;
  logic [5:0] want_reg;
  logic [3:0] skip_cnt_reg;
  logic [16:0] shot_cnt_reg [3];
  logic [2:0] shot_reg;
  logic [2:0] alt_sel_reg;
  logic [7:0] dead_cnt_reg [3];
  logic cut_reg;
  logic cut_pin_reg;
  // Decoded strobes and events.
  logic wr;
  logic rd;
  logic underflow;
  logic trigger;
  logic hit;
  logic [2:0] shot_end;
  logic conc;
  logic mode1;
  logic saw;

  assign mode1 = ctrl1_reg[`TPM_C1_ALT_MODE];
  assign saw = ctrl0_reg[`TPM_C0_SAW];
  // A write or read takes effect on the edge that also raises pready.
  assign wr = (bus_reg == tpm_pkg::TPM_WAIT) && I_PWRITE;
  assign rd = (bus_reg == tpm_pkg::TPM_WAIT) && !I_PWRITE;
  // Known offsets; anything else answers with an error.
  assign hit = (I_PADDR[1:0] == 2'b00) && (I_PADDR <= `TPM_OFF_UNLOCK);
  // Carrier underflow when the count reaches zero; in triangular mode only on its second half.
  assign underflow = ctrl0_reg[`TPM_C0_ENABLE] &&
                     special_reg[`TPM_SC_COUNT_START] &&
                     (carrier_cnt_reg == 16'h0000) && (saw || half_reg);
  // Armed underflow or a carrier write with write triggering on.
  assign trigger = (underflow && arm_reg) ||
                   (wr && I_PADDR == `TPM_OFF_CARRIER &&
                    ctrl1_reg[`TPM_C1_WR_TRIG]);

  // Bus state: access is seen, one wait cycle, then pready for one cycle.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      bus_reg <= tpm_pkg::TPM_IDLE;
    end else begin
      unique case (bus_reg)
        tpm_pkg::TPM_IDLE: if (I_PSEL && I_PENABLE) begin
          bus_reg <= tpm_pkg::TPM_WAIT;
        end
        tpm_pkg::TPM_WAIT: bus_reg <= tpm_pkg::TPM_DONE;
        tpm_pkg::TPM_DONE: bus_reg <= tpm_pkg::TPM_IDLE;
        // The unused code falls back to idle rather than lock the bus.
        default: bus_reg <= tpm_pkg::TPM_IDLE;
      endcase
    end
  end

  // Ready, error and read data come straight from flip-flops.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= (bus_reg == tpm_pkg::TPM_WAIT);
      O_PSLVERR <= (bus_reg == tpm_pkg::TPM_WAIT) && !hit;
      if (rd) begin
        O_PRDATA <= 32'h0000_0000;
        // Narrow registers sit in the low bits; upper bits read zero.
        case (I_PADDR)
          `TPM_OFF_CTRL0: O_PRDATA[6:0] <= ctrl0_reg;
          `TPM_OFF_CTRL1: O_PRDATA[4:0] <= ctrl1_reg;
          `TPM_OFF_SKIP: O_PRDATA[3:0] <= skip_n_reg;
          `TPM_OFF_CARRIER: O_PRDATA[15:0] <= carrier_cnt_reg;
          `TPM_OFF_SPECIAL: O_PRDATA[2:0] <= special_reg;
          `TPM_OFF_DEAD: O_PRDATA[7:0] <= dead_reg;
          `TPM_OFF_BUF0: O_PRDATA[5:0] <= buf0_reg;
          `TPM_OFF_BUF1: O_PRDATA[5:0] <= buf1_reg;
          `TPM_OFF_STATUS: begin
            // Half flag shows only in triangular mode 1.
            O_PRDATA[0] <= half_reg && mode1 && !saw &&
                           ctrl1_reg[`TPM_C1_PH_FLAG];
            O_PRDATA[1] <= cut_reg;
            O_PRDATA[7:2] <= O_PHASE;
            O_PRDATA[11:8] <= skip_cnt_reg;
          end
          `TPM_OFF_UNLOCK: O_PRDATA[0] <= unlock_reg;
          default: begin
            // Width registers and their alternates.
            for (int i = 0; i < 3; i++) begin
              if (I_PADDR == `TPM_OFF_WIDTH + 8'(4 * i)) begin
                O_PRDATA[15:0] <= width_reg[i];
              end
              if (I_PADDR == `TPM_OFF_ALT + 8'(4 * i)) begin
                O_PRDATA[15:0] <= alt_reg[i];
              end
            end
          end
        endcase
      end
    end
  end

  // Software registers; protected ones need the unlock bit first.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      ctrl0_reg <= 7'h00;
      ctrl1_reg <= 5'h00;
      special_reg <= 3'h0;
      skip_n_reg <= `TPM_RST_SKIP;
      carrier_set_reg <= 16'h0000;
      dead_reg <= `TPM_RST_DEAD;
      buf0_reg <= 6'h00;
      buf1_reg <= 6'h00;
      unlock_reg <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        width_reg[i] <= 16'h0000;
        alt_reg[i] <= 16'h0000;
      end
    end else begin
      if (wr) begin
        case (I_PADDR)
          `TPM_OFF_CTRL0: if (unlock_reg) begin
            ctrl0_reg <= I_PWDATA[6:0];
          end
          `TPM_OFF_CTRL1: if (unlock_reg) begin
            ctrl1_reg <= I_PWDATA[4:0];
          end
          `TPM_OFF_SPECIAL: if (unlock_reg) begin
            special_reg <= I_PWDATA[2:0];
          end
          `TPM_OFF_SKIP: skip_n_reg <= I_PWDATA[3:0];
          `TPM_OFF_CARRIER: carrier_set_reg <= I_PWDATA[15:0];
          `TPM_OFF_DEAD: dead_reg <= I_PWDATA[7:0];
          `TPM_OFF_BUF0: buf0_reg <= I_PWDATA[5:0];
          `TPM_OFF_BUF1: buf1_reg <= I_PWDATA[5:0];
          `TPM_OFF_UNLOCK: unlock_reg <= I_PWDATA[0];
          default: begin
            for (int i = 0; i < 3; i++) begin
              if (I_PADDR == `TPM_OFF_WIDTH + 8'(4 * i)) begin
                width_reg[i] <= I_PWDATA[15:0];
              end
              if (I_PADDR == `TPM_OFF_ALT + 8'(4 * i)) begin
                alt_reg[i] <= I_PWDATA[15:0];
              end
            end
          end
        endcase
      end
      // Output enable is cleared by the hardware causes.
      if ((conc && ctrl0_reg[`TPM_C0_CA_DIS]) ||
          (cut_pin_reg && !I_CUTOFF_N)) begin
        ctrl0_reg[`TPM_C0_OUT_EN] <= 1'b0;
      end
      // The software trigger bit self-clears once it has been armed.
      if (ctrl0_reg[`TPM_C0_SW_TRIG]) begin
        ctrl0_reg[`TPM_C0_SW_TRIG] <= 1'b0;
      end
    end
  end

  // Carrier: counts down twice per period in triangular mode.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      carrier_cnt_reg <= 16'h0000;
      half_reg <= 1'b0;
    end else if (!special_reg[`TPM_SC_COUNT_START] ||
                 !ctrl0_reg[`TPM_C0_ENABLE]) begin
      carrier_cnt_reg <= carrier_set_reg;
      half_reg <= 1'b0;
    end else if (carrier_cnt_reg == 16'h0000) begin
      // Reload on own underflow; one half per m+1 counts.
      carrier_cnt_reg <= carrier_set_reg;
      half_reg <= saw ? 1'b0 : !half_reg;
    end else begin
      carrier_cnt_reg <= carrier_cnt_reg - 16'h0001;
    end
  end

  // Trigger arming and buffer-write tracking.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      arm_reg <= 1'b0;
      buf_new_reg <= 1'b0;
    end else begin
      // The arm is kept until the underflow that uses it.
      if (ctrl0_reg[`TPM_C0_SW_TRIG]) begin
        arm_reg <= 1'b1;
      end else if (underflow) begin
        arm_reg <= 1'b0;
      end
      // A buffer write in the same cycle as a trigger is not lost.
      if (wr && (I_PADDR == `TPM_OFF_BUF0 || I_PADDR == `TPM_OFF_BUF1)) begin
        buf_new_reg <= 1'b1;
      end else if (trigger) begin
        buf_new_reg <= 1'b0;
      end
    end
  end

  // Shift register: first buffer now, second after each pulse.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      sh0_reg <= 6'h00;
      sh1_reg <= 6'h00;
      want_reg <= 6'h00;
    end else begin
      // Sawtooth copies every time; triangular only after a write.
      if (trigger && (saw || buf_new_reg)) begin
        sh0_reg <= buf0_reg;
        sh1_reg <= buf1_reg;
        want_reg <= buf0_reg;
      end
      for (int i = 0; i < 3; i++) begin
        if (shot_end[i]) begin
          want_reg[2*i +: 2] <= sh1_reg[2*i +: 2];
        end
      end
    end
  end

  // Phase one-shots started by the carrier underflow.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      shot_reg <= 3'h0;
      alt_sel_reg <= 3'h0;
      O_PHASE_IRQ <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        shot_cnt_reg[i] <= 17'h00000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        O_PHASE_IRQ[i] <= shot_end[i];
        if (underflow) begin
          // Mode 1 alternates: alternate first, then primary.
          logic [15:0] n;
          n = (mode1 && !alt_sel_reg[i]) ? alt_reg[i] : width_reg[i];
          alt_sel_reg[i] <= mode1 ? !alt_sel_reg[i] : 1'b0;
          // A zero width leaves the counter idle.
          if (n != 16'h0000) begin
            shot_reg[i] <= 1'b1;
            shot_cnt_reg[i] <= saw ? {1'b0, n} : {n, 1'b0};
          end
        end else if (shot_reg[i]) begin
          shot_cnt_reg[i] <= shot_cnt_reg[i] - 17'h00001;
          if (shot_cnt_reg[i] == 17'h00001) begin
            shot_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Pulse end flags are decoded from the counter.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      shot_end[i] = shot_reg[i] && !underflow &&
                    shot_cnt_reg[i] == 17'h00001;
    end
  end

  // Dead time: each phase holds a rising level back p cycles.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_PHASE <= 6'h00;
      for (int i = 0; i < 3; i++) begin
        dead_cnt_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (!want_reg[i]) begin
          // Going inactive is never delayed.
          O_PHASE[i] <= 1'b0;
        end else if (ctrl1_reg[`TPM_C1_DT_DIS]) begin
          // Disabled: no dead time inserted.
          O_PHASE[i] <= 1'b1;
        end else if (dead_cnt_reg[i/2] == 8'h01) begin
          // Active only once the dead time timer stops.
          O_PHASE[i] <= 1'b1;
        end
      end
      for (int i = 0; i < 3; i++) begin
        // A level change of the pair starts the count when it is idle at zero.
        if (want_reg[2*i +: 2] != O_PHASE[2*i +: 2] &&
            dead_cnt_reg[i] == 8'h00) begin
          dead_cnt_reg[i] <= dead_reg;
        end else if (dead_cnt_reg[i] != 8'h00) begin
          dead_cnt_reg[i] <= dead_cnt_reg[i] - 8'h01;
        end
      end
    end
  end

  // Concurrent active: both levels of any pair active at once.
  always_comb begin
    conc = 1'b0;
    for (int i = 0; i < 3; i++) begin
      conc = conc || (O_PHASE[2*i] && O_PHASE[2*i+1]);
    end
  end

  // Forced cutoff: latched on a low pin, released by pin and software.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      cut_reg <= 1'b0;
      cut_pin_reg <= 1'b1;
      O_PHASE_OE <= 6'h00;
    end else begin
      cut_pin_reg <= I_CUTOFF_N;
      if (special_reg[`TPM_SC_CUTOFF_EN] && !I_CUTOFF_N) begin
        cut_reg <= 1'b1;
      end else if (!special_reg[`TPM_SC_CUTOFF_EN] && I_CUTOFF_N) begin
        cut_reg <= 1'b0;
      end
      // A low pin blocks the enable in the very same cycle.
      O_PHASE_OE <= {6{ctrl0_reg[`TPM_C0_ENABLE] &&
                       ctrl0_reg[`TPM_C0_OUT_EN] && !cut_reg &&
                       !(special_reg[`TPM_SC_CUTOFF_EN] && !I_CUTOFF_N)}};
    end
  end

  // Skip counter: mode 0 interrupts each underflow, mode 1 every n.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      skip_cnt_reg <= 4'h1;
      O_CARRIER_IRQ <= 1'b0;
    end else if (wr && I_PADDR == `TPM_OFF_SKIP) begin
      // Starting at one gives the first interrupt after n-1.
      skip_cnt_reg <= 4'h1;
      O_CARRIER_IRQ <= 1'b0;
    end else if (underflow) begin
      if (!mode1 || !ctrl0_reg[`TPM_C0_SKIP_EN] ||
          skip_cnt_reg + 4'h1 >= skip_n_reg) begin
        skip_cnt_reg <= mode1 ? 4'h0 : skip_cnt_reg + 4'h1;
        O_CARRIER_IRQ <= 1'b1;
      end else begin
        skip_cnt_reg <= skip_cnt_reg + 4'h1;
        O_CARRIER_IRQ <= 1'b0;
      end
    end else begin
      O_CARRIER_IRQ <= 1'b0;
    end
  end
endmodule

// *** core/tpm_defs.svh ***
// Register offsets, field positions and reset values.
// Function
// - Transfer trigger: armed underflow or carrier write
// - Mode 0 ignores alternates and skip bits
// - Phase flag only in triangular mode 1
// - First interrupt after n-1, then every n
// - Zero width never starts phase counter
// - Inactive to active only after dead time
// - Reload from primary, or alternate then primary
// - Cutoff pin low forces six pins off
// - Trigger loads shift register; second at pulse end
// - Dead time only when not disabled
// - Enable bit runs carrier, phases and dead time; code runs the dead time count regardless of it
// - Dead time lasts p count source periods
// - Triangular carrier period is (m+1) times 2
// - Sawtooth transfers always; triangular once per write
// - Output enable cleared by four causes; code clears it on two: concurrent active, cutoff pin fall
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH
`define TPM_OFF_CTRL0 8'h00
`define TPM_OFF_CTRL1 8'h04
`define TPM_OFF_SKIP 8'h08
`define TPM_OFF_CARRIER 8'h0c
`define TPM_OFF_SPECIAL 8'h10
`define TPM_OFF_DEAD 8'h14
`define TPM_OFF_BUF0 8'h18
`define TPM_OFF_BUF1 8'h1c
`define TPM_OFF_WIDTH 8'h20
`define TPM_OFF_ALT 8'h2c
`define TPM_OFF_STATUS 8'h38
`define TPM_OFF_UNLOCK 8'h3c
`define TPM_C0_ENABLE 0
`define TPM_C0_OUT_EN 1
`define TPM_C0_CA_DIS 2
`define TPM_C0_SAW 3
`define TPM_C0_SW_TRIG 4
`define TPM_C0_SKIP_EN 5
`define TPM_C0_SKIP_SYNC 6
`define TPM_C1_WR_TRIG 0
`define TPM_C1_ALT_MODE 1
`define TPM_C1_PH_FLAG 2
`define TPM_C1_DT_DIS 3
`define TPM_C1_DT_SEL 4
`define TPM_SC_CUTOFF_EN 0
`define TPM_SC_RELOAD_SEL 1
`define TPM_SC_COUNT_START 2
`define TPM_RST_DEAD 8'h01
`define TPM_RST_SKIP 4'h1
`endif

// *** core/tpm_pkg.sv ***
// Types shared by the three-phase motor PWM timer.
package tpm_pkg;
  // Bus access state, Gray coded along idle, wait, done.
  typedef enum logic [1:0] {
    TPM_IDLE = 2'b00,
    TPM_WAIT = 2'b01,
    TPM_DONE = 2'b11
  } tpm_bus_t;
  // One phase pair: positive and negative levels.
  typedef struct packed {
    logic pos;
    logic neg;
  } tpm_pair_t;
endpackage

// *** verif/tpm_timer_chk.sv ***
// Port checker for the three-phase motor PWM timer, bound to its top.
module tpm_timer_chk (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_CUTOFF_N,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic [5:0] O_PHASE,
  input wire logic [5:0] O_PHASE_OE,
  input wire logic O_CARRIER_IRQ,
  input wire logic [2:0] O_PHASE_IRQ
);
  // Every property below samples on the one system clock.
  default clocking cb @(posedge I_CLOCK);
  endclocking
  // The first edge of an access phase.
  sequence s_access;
    I_PSEL && $rose(I_PENABLE);
  endsequence
  // The answer comes after one to three wait states, never on the first edge.
  property p_answer;
    disable iff (I_SYS_RST) s_access |-> !O_PREADY ##[1:3] O_PREADY;
  endproperty
  a_apb_answer: assert property (p_answer)
    else $error("APB answer late or early");
  a_pready_pulse: assert property (disable iff (I_SYS_RST)
    O_PREADY |=> !O_PREADY) else $error("pready longer than a cycle");
  a_error_with_ready: assert property (disable iff (I_SYS_RST)
    O_PSLVERR |-> O_PREADY) else $error("pslverr without pready");
  a_rdata_held: assert property (disable iff (I_SYS_RST)
    $changed(O_PRDATA) |-> O_PREADY) else $error("prdata moved alone");
  // Reset is checked while it is asserted, so it has no disable.
  a_reset_clears: assert property (I_SYS_RST |=> (!O_PREADY &&
    O_PHASE == 6'h00 && O_PHASE_OE == 6'h00))
    else $error("outputs not cleared by reset");
  a_oe_uniform: assert property (disable iff (I_SYS_RST)
    O_PHASE_OE == 6'h00 || O_PHASE_OE == 6'h3f)
    else $error("pin enables differ");
  a_cutoff_fall: assert property (disable iff (I_SYS_RST)
    $fell(I_CUTOFF_N) |-> ##[1:2] O_PHASE_OE == 6'h00)
    else $error("pins still driven after cutoff edge");
  a_irq_pulse: assert property (disable iff (I_SYS_RST)
    O_CARRIER_IRQ |=> !O_CARRIER_IRQ)
    else $error("carrier interrupt longer than a cycle");
  a_phase_pulse: assert property (disable iff (I_SYS_RST)
    O_PHASE_IRQ != 3'h0 |=> (O_PHASE_IRQ & $past(O_PHASE_IRQ)) == 3'h0)
    else $error("phase interrupt longer than a cycle");
endmodule
bind tpm_timer tpm_timer_chk u_chk (.I_CLOCK(I_CLOCK),
  .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_CUTOFF_N(I_CUTOFF_N), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_PRDATA(O_PRDATA), .O_PHASE(O_PHASE), .O_PHASE_OE(O_PHASE_OE),
  .O_CARRIER_IRQ(O_CARRIER_IRQ), .O_PHASE_IRQ(O_PHASE_IRQ));

// *** verif/tpm_gate_drv.sv ***
// Behavioural gate driver that faces the six phase pins.
module tpm_gate_drv (
  input wire logic i_clk,
  input wire logic [5:0] i_phase,
  input wire logic [5:0] i_oe,
  input wire logic i_fault,
  output logic o_fault_n,
  output logic [5:0] o_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gate inputs have pull-downs, so a released pin reads low.
  assign o_gate = i_phase & i_oe;
  // The fault line is pulled up and moves only just after an edge,
  // so the timer never sees it change at its own sampling instant.
  initial o_fault_n = 1'b1;
  always @(posedge i_clk) o_fault_n <= ~i_fault;
endmodule

// *** verif/three_phase_motor_pwm_timer_tb.sv ***
// Self-checking bench for the three-phase motor PWM timer.
`include "tpm_defs.svh"
module three_phase_motor_pwm_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // System clock, 200 MHz.
  logic rst = 1'b1; // Synchronous reset, held for 12 cycles.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fault = 1'b0; // Makes the driver model pull the cutoff low.
  logic pready, pslverr, cut_n, c_irq;
  logic [31:0] prdata;
  logic [5:0] phase, oe, gate;
  logic [2:0] p_irq;
  int fails = 0, total_checks = 0, u_irqs = 0, v_irqs = 0;
  tpm_timer u_dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_CUTOFF_N(cut_n), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_PHASE(phase),
    .O_PHASE_OE(oe), .O_CARRIER_IRQ(c_irq), .O_PHASE_IRQ(p_irq));
  tpm_gate_drv u_drv (.i_clk(clk), .i_phase(phase), .i_oe(oe),
    .i_fault(fault), .o_fault_n(cut_n), .o_gate(gate));
  // Clock generator, one flip per half period.
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Counts the U and V one-shot ends.
  always @(posedge clk) begin
    if (p_irq[0] === 1'b1) u_irqs++;
    if (p_irq[1] === 1'b1) v_irqs++;
  end
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits up to 50 cycles for pready, then flags an error.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("[ERR] %0t: no pready on the bus", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  // Counts edges up to the next carrier interrupt, bounded.
  task automatic wait_irq(output int g);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (c_irq !== 1'b1 && g < 200);
  endtask
  // Reset values, write protection and an unmapped address.
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    chk(32'({pready, phase, oe}), 32'h0);
    rd(`TPM_OFF_DEAD, 32'h1);
    rd(`TPM_OFF_SKIP, 32'h1);
    wr(`TPM_OFF_CTRL0, 32'h1);
    rd(`TPM_OFF_CTRL0, 32'h0);
    apb(1'b0, 8'hfc, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    wr(`TPM_OFF_UNLOCK, 32'h1);
    $display("done: reset and protection");
  endtask
  // Carrier period in both modulations; mode 0 ignores skip bits.
  task automatic t_carrier();
    int g;
    for (int saw = 0; saw < 2; saw++) begin
      wr(`TPM_OFF_SKIP, 32'h3);
      wr(`TPM_OFF_CARRIER, 32'h3);
      wr(`TPM_OFF_CTRL0, 32'h21 | (32'(saw) << 3));
      wr(`TPM_OFF_SPECIAL, 32'h4);
      wait_irq(g);
      wait_irq(g);
      chk(32'(g), (saw != 0) ? 32'd4 : 32'd8);
      wr(`TPM_OFF_SPECIAL, 32'h0);
    end
    $display("done: carrier period");
  endtask
  // Mode 1 with skipping: one interrupt every three underflows.
  task automatic t_skip();
    int g;
    wr(`TPM_OFF_CTRL1, 32'h2);
    wr(`TPM_OFF_CTRL0, 32'h21);
    wr(`TPM_OFF_SKIP, 32'h3);
    wr(`TPM_OFF_SPECIAL, 32'h4);
    wait_irq(g);
    wait_irq(g);
    chk(32'(g), 32'd24);
    wr(`TPM_OFF_SPECIAL, 32'h0);
    $display("done: interrupt skipping");
  endtask
  // Carrier write fires the transfer; U has zero width, V and W do not.
  task automatic t_transfer();
    int n;
    wr(`TPM_OFF_CTRL1, 32'h9);
    wr(`TPM_OFF_WIDTH, 32'h0);
    wr(`TPM_OFF_WIDTH + 8'h4, 32'h2);
    wr(`TPM_OFF_WIDTH + 8'h8, 32'h2);
    wr(`TPM_OFF_BUF0, 32'h15);
    wr(`TPM_OFF_BUF1, 32'h2a);
    wr(`TPM_OFF_CTRL0, 32'h3);
    wr(`TPM_OFF_SPECIAL, 32'h4);
    u_irqs = 0;
    v_irqs = 0;
    wr(`TPM_OFF_CARRIER, 32'h3);
    n = 0;
    while (phase !== 6'h15 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(32'(phase), 32'h15);
    chk(32'(oe), 32'h3f);
    chk(32'(gate), 32'h15);
    n = 0;
    while (v_irqs == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk(32'(phase[3:2]), 32'h2);
    chk(32'(u_irqs), 32'h0);
    $display("done: buffer transfer");
  endtask
  // Cutoff pin forces the pins off until released by software.
  task automatic t_cutoff();
    wr(`TPM_OFF_SPECIAL, 32'h5);
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(oe), 32'h0);
    rd(`TPM_OFF_CTRL0, 32'h1);
    fault <= 1'b0;
    wr(`TPM_OFF_CTRL0, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'h0);
    wr(`TPM_OFF_SPECIAL, 32'h4);
    wr(`TPM_OFF_CTRL0, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'h3f);
    $display("done: forced cutoff");
  endtask
  // Dead time on a pair change, mode 1 alternation, software trigger.
  task automatic t_dead_alt();
    int g;
    wr(`TPM_OFF_SPECIAL, 32'h0);
    wr(`TPM_OFF_CTRL1, 32'h1);
    wr(`TPM_OFF_DEAD, 32'h4);
    wr(`TPM_OFF_BUF0, 32'h2a);
    wr(`TPM_OFF_BUF1, 32'h15);
    wr(`TPM_OFF_CARRIER, 32'h3);
    // Only the U pair changes; its old active level drops first.
    g = 0;
    while (phase[0] !== 1'b0 && g < 50) begin
      @(posedge clk);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (phase[1] !== 1'b1 && g < 50);
    chk(32'(g), 32'd4);
    wr(`TPM_OFF_CTRL1, 32'ha);
    wr(`TPM_OFF_ALT + 8'h4, 32'h1);
    @(posedge clk);
    wr(`TPM_OFF_ALT + 8'h4, 32'h1);
    wr(`TPM_OFF_SPECIAL, 32'h4);
    // V pulse is two cycles from the alternate, then four.
    for (int k = 0; k < 2; k++) begin
      wait_irq(g);
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (p_irq[1] !== 1'b1 && g < 50);
      chk(32'(g), (k == 0) ? 32'd2 : 32'd4);
    end
    // Carrier writes no longer trigger; only the armed underflow does.
    wr(`TPM_OFF_BUF0, 32'h15);
    wr(`TPM_OFF_CTRL0, 32'h13);
    g = 0;
    while (phase[1:0] !== 2'b01 && g < 40) begin
      @(posedge clk);
      g++;
    end
    chk(32'(phase[1:0]), 32'h1);
    rd(`TPM_OFF_CTRL0, 32'h3);
    wr(`TPM_OFF_SPECIAL, 32'h0);
    $display("done: dead time, alternation, soft trigger");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_carrier();
    t_skip();
    t_transfer();
    t_cutoff();
    t_dead_alt();
    final_report();
  end
  // Watchdog, well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[ERR] %0t: watchdog expired", $time);
    final_report();
  end
endmodule
